// ### prbs_scrambler_conv_encoder.v
// energy dispersal scrambler feeding a rate-1/4 convolutional mother encoder
`timescale 1ns/1ps
`include "scrambler_conv_consts.vh"
module prbs_scrambler_conv_encoder (
  input  wire clk_in,
  input  wire rst_in,
  input  wire bit_in,
  input  wire bit_valid_in,
  input  wire frame_start_in,
  input  wire frame_last_in,
  output reg  bit_ready_out,
  input  wire code_ready_in,
  output reg  code_bit_out,
  output reg  code_valid_out,
  output reg  code_first_out,
  output reg  code_last_out,
  output reg  frame_error_out
);
  localparam ST_DATA  = 2'h0;
  localparam ST_FLUSH = 2'h1;

  ////////////////////////////////////////////////////////////////////////////
  // scrambler and encoder, one input index per accepted group
  reg [`PRBS_LEN-1:0] prbs_reg;
  reg [`CONV_MEM-1:0] conv_reg;
  reg [1:0]           state_reg;
  reg [2:0]           flush_cnt_reg;
  reg                 in_frame_reg;
  wire                buf_ready;
  wire [6:0]          grp_first_last;
  wire [5:0]          buf_out;
  wire                buf_valid;
  reg                 ser_load;

  // registered ready toggles a cycle late, so gate the take on the live term
  wire take_in = bit_valid_in && bit_ready_out && (state_reg == ST_DATA) && buf_ready;
  wire flush_go = (state_reg == ST_FLUSH) && buf_ready;

  wire [`PRBS_LEN-1:0] prbs_cur = frame_start_in ? `PRBS_SEED : prbs_reg;
  wire prbs_bit = prbs_cur[`PRBS_TAP_A] ^ prbs_cur[`PRBS_TAP_B];
  wire scr_bit  = bit_in ^ prbs_bit;
  // zero state only when the start bit is really taken: an early offer of the
  // next frame during the flush must not clear the tail of the current one
  wire [`CONV_MEM-1:0] conv_cur = (take_in && frame_start_in) ? {`CONV_MEM{1'b0}} : conv_reg;
  wire a_bit = take_in ? scr_bit : 1'b0;
  wire [6:0] win = {a_bit, conv_cur};
  wire x0_bit = ^(win & `CONV_G0);
  wire x1_bit = ^(win & `CONV_G1);
  wire x2_bit = ^(win & `CONV_G2);
  wire x3_bit = ^(win & `CONV_G3);
  wire [3:0] grp = {x3_bit, x2_bit, x1_bit, x0_bit};
  wire grp_first = take_in && frame_start_in;
  wire grp_last  = flush_go && (flush_cnt_reg == (`CONV_FLUSH - 3'h1));

  assign grp_first_last = {grp_first, grp_last, grp, 1'b0};

  ////////////////////////////////////////////////////////////////////////////
  // input handshake
  // ready only when the buffer surely has room at the next edge; the idle
  // cycle after each take halves the input rate, still above the 1:4 output
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      bit_ready_out <= 1'b0;
    end else begin
      bit_ready_out <= (state_reg == ST_DATA) && buf_ready && !take_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // scrambler register, advanced once per taken bit
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      prbs_reg <= `PRBS_SEED;
    end else if (take_in) begin
      prbs_reg <= {prbs_cur[`PRBS_LEN-2:0], prbs_bit};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // encoder register: data bits, then zero bits while flushing
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      conv_reg <= {`CONV_MEM{1'b0}};
    end else if (take_in) begin
      conv_reg <= {a_bit, conv_cur[`CONV_MEM-1:1]};
    end else if (flush_go) begin
      conv_reg <= {1'b0, conv_reg[`CONV_MEM-1:1]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // framing error flag
  // a bit without a preceding frame start is flagged, encoded anyway
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      frame_error_out <= 1'b0;
    end else if (take_in) begin
      frame_error_out <= !frame_start_in && !in_frame_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame control: data phase, then six flush groups
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg     <= ST_DATA;
      flush_cnt_reg <= 3'h0;
      in_frame_reg  <= 1'b0;
    end else begin
      case (state_reg)
        ST_DATA: begin
          if (take_in) begin
            in_frame_reg <= 1'b1;
            if (frame_last_in) begin
              state_reg     <= ST_FLUSH;
              flush_cnt_reg <= 3'h0;
            end
          end
        end
        ST_FLUSH: begin
          if (flush_go) begin
            flush_cnt_reg <= flush_cnt_reg + 3'h1;
            if (grp_last) begin
              state_reg    <= ST_DATA;
              in_frame_reg <= 1'b0;
            end
          end
        end
        default: begin
          state_reg <= ST_DATA;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // group buffer so a downstream stall loses nothing
  skid_buffer2 #(
    .WIDTH (6)
  ) u_grp_buf (
    .clk_in       (clk_in),
    .rst_in       (rst_in),
    .wr_data_in   (grp_first_last[6:1]),
    .wr_valid_in  (take_in || flush_go),
    .wr_ready_out (buf_ready),
    .rd_data_out  (buf_out),
    .rd_valid_out (buf_valid),
    .rd_ready_in  (ser_load)
  );

  ////////////////////////////////////////////////////////////////////////////
  // serializer: output 0 first, four bits per group
  reg [3:0] sh_reg;
  reg [1:0] ser_cnt_reg;
  reg       ser_busy_reg;
  reg       ser_first_reg;
  reg       ser_last_reg;
  wire      ser_adv = code_valid_out && code_ready_in;
  wire      ser_free = !ser_busy_reg || (ser_adv && ser_cnt_reg == 2'h3);

  always @* begin
    ser_load = buf_valid && ser_free;
  end

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sh_reg         <= 4'h0;
      ser_cnt_reg    <= 2'h0;
      ser_busy_reg   <= 1'b0;
      ser_first_reg  <= 1'b0;
      ser_last_reg   <= 1'b0;
      code_bit_out   <= 1'b0;
      code_valid_out <= 1'b0;
      code_first_out <= 1'b0;
      code_last_out  <= 1'b0;
    end else begin
      if (ser_load) begin
        sh_reg         <= {1'b0, buf_out[3:1]};
        ser_cnt_reg    <= 2'h0;
        ser_busy_reg   <= 1'b1;
        ser_first_reg  <= buf_out[5];
        ser_last_reg   <= buf_out[4];
        code_bit_out   <= buf_out[0];
        code_valid_out <= 1'b1;
        code_first_out <= buf_out[5];
        code_last_out  <= 1'b0;
      end else if (ser_adv) begin
        if (ser_cnt_reg == 2'h3) begin
          ser_busy_reg   <= 1'b0;
          code_valid_out <= 1'b0;
          code_last_out  <= 1'b0;
        end else begin
          ser_cnt_reg    <= ser_cnt_reg + 2'h1;
          code_bit_out   <= sh_reg[0];
          sh_reg         <= {1'b0, sh_reg[3:1]};
          code_first_out <= 1'b0;
          code_last_out  <= ser_last_reg && (ser_cnt_reg == 2'h2);
        end
      end
    end
  end
endmodule // prbs_scrambler_conv_encoder

// ### scrambler_conv_consts.vh
// constants for the scrambler and convolutional mother encoder
`ifndef SCRAMBLER_CONV_CONSTS_VH
`define SCRAMBLER_CONV_CONSTS_VH
`define PRBS_LEN        9
`define PRBS_SEED       9'h1FF
`define PRBS_TAP_A      8
`define PRBS_TAP_B      4
`define CONV_MEM        6
`define CONV_FLUSH      3'h6
`define CONV_G0         7'h5B
`define CONV_G1         7'h79
`define CONV_G2         7'h65
`define CONV_G3         7'h5B
`define FIC_VECTOR_BITS 10'h300
`endif

// ### skid_buffer2.v
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module skid_buffer2 #(
  parameter WIDTH = 4
) (
  input  wire             clk_in,
  input  wire             rst_in,
  input  wire [WIDTH-1:0] wr_data_in,
  input  wire             wr_valid_in,
  output wire             wr_ready_out,
  output wire [WIDTH-1:0] rd_data_out,
  output wire             rd_valid_out,
  input  wire             rd_ready_in
);
  reg [WIDTH-1:0] mem_reg [0:1];
  reg             wr_ptr_reg;
  reg             rd_ptr_reg;
  reg [1:0]       count_reg;
  wire            do_wr;
  wire            do_rd;

  assign do_wr        = wr_valid_in && (count_reg != 2'h2);
  assign do_rd        = rd_ready_in && (count_reg != 2'h0);
  assign wr_ready_out = (count_reg != 2'h2);
  assign rd_valid_out = (count_reg != 2'h0);
  assign rd_data_out  = mem_reg[rd_ptr_reg];

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
      mem_reg[0] <= {WIDTH{1'b0}};
      mem_reg[1] <= {WIDTH{1'b0}};
    end else begin
      if (do_wr) begin
        mem_reg[wr_ptr_reg] <= wr_data_in;
        wr_ptr_reg          <= ~wr_ptr_reg;
      end
      if (do_rd)
        rd_ptr_reg <= ~rd_ptr_reg;
      count_reg <= count_reg + {1'b0, do_wr} - {1'b0, do_rd};
    end
  end
endmodule // skid_buffer2

// ### code_sink_model.sv
// downstream puncturing-side sink model that stalls on a fixed pattern
`timescale 1ns/1ps
module code_sink_model (
  input  wire  clk_in,
  input  wire  rst_in,
  output logic code_ready_out
);
  logic [2:0] phase_reg;
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) phase_reg <= 3'h0;
    else phase_reg <= phase_reg + 3'h1;
  end
  // two stall cycles in eight keep the buffer and hold logic busy
  assign code_ready_out = (phase_reg < 3'h6);
endmodule // code_sink_model

// ### prbs_scrambler_conv_encoder_properties.sv
// port checker for the scrambler and mother encoder
`timescale 1ns/1ps
module prbs_scrambler_conv_encoder_properties (
  input wire clk_in, rst_in, bit_in, bit_valid_in, frame_start_in, frame_last_in, bit_ready_out,
  input wire code_ready_in, code_bit_out, code_valid_out, code_first_out, code_last_out, frame_error_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  wire take = bit_valid_in && bit_ready_out;
  reg  first_bit_reg;
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) first_bit_reg <= 1'b0;
    else if (take && frame_start_in) first_bit_reg <= bit_in;
  end
  sequence last_take; take && frame_last_in; endsequence
  sequence stall; code_valid_out && !code_ready_in; endsequence
  stall_hold_a: assert property (stall |=> code_valid_out && $stable({code_bit_out, code_first_out, code_last_out}))
    else $error("code output moved while stalled");
  valid_drop_a: assert property ($fell(code_valid_out) |-> $past(code_ready_in))
    else $error("code valid dropped without accept");
  first_marker_a: assert property (code_first_out |-> code_valid_out) else $error("first marker without valid");
  last_marker_a: assert property (code_last_out |-> code_valid_out) else $error("last marker without valid");
  flush_refuse_a: assert property (last_take |=> !bit_ready_out [*8]) else $error("input taken during flush");
  start_answer_a: assert property (take && frame_start_in |-> ##[1:100] (code_valid_out && code_first_out))
    else $error("no first code bit after frame start");
  // state zero and seed bit 0 make the first code bit equal the first data bit
  first_bit_a: assert property (code_valid_out && code_first_out |-> code_bit_out == first_bit_reg)
    else $error("first code bit wrong");
  error_clear_a: assert property (take && frame_start_in |=> !frame_error_out)
    else $error("error flag set on framed start");
endmodule // prbs_scrambler_conv_encoder_properties

// ### prbs_scrambler_conv_encoder_tb_top.sv
// testbench for the scrambler and mother encoder
`timescale 1ns/1ps
module prbs_scrambler_conv_encoder_tb_top;
  logic clk_in = 1'b0, rst_in = 1'b1, bit_in = 1'b0, bit_valid_in = 1'b0, frame_start_in = 1'b0, frame_last_in = 1'b0;
  wire  bit_ready_out, code_ready_in, code_bit_out, code_valid_out, code_first_out, code_last_out, frame_error_out;
  int   failures = 0, tests_run = 0, cycles = 0;
  logic [2:0] got_q[$], exp_q[$];
  always #2 clk_in = ~clk_in;
  prbs_scrambler_conv_encoder i_prbs_scrambler_conv_encoder (.clk_in(clk_in), .rst_in(rst_in), .bit_in(bit_in),
    .bit_valid_in(bit_valid_in), .frame_start_in(frame_start_in), .frame_last_in(frame_last_in),
    .bit_ready_out(bit_ready_out), .code_ready_in(code_ready_in), .code_bit_out(code_bit_out),
    .code_valid_out(code_valid_out), .code_first_out(code_first_out), .code_last_out(code_last_out),
    .frame_error_out(frame_error_out));
  code_sink_model i_code_sink_model (.clk_in(clk_in), .rst_in(rst_in), .code_ready_out(code_ready_in));
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (code_valid_out === 1'b1 && code_ready_in === 1'b1) got_q.push_back({code_first_out, code_last_out, code_bit_out});
    if (cycles == 20000) begin failures = failures + 1; finish_test(); end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [2:0] seen, input logic [2:0] expd);
    tests_run++;
    if (seen !== expd) begin failures++; $display("mismatch at %0t: got %b expected %b", $time, seen, expd); end
  endtask
  // reference: {first, last, bit} per code bit, prbs and encoder restarted each frame
  task automatic expect_frame(input int n, input logic [31:0] d);
    logic [8:0] p; logic [5:0] m; logic [6:0] w; logic a; int i;
    p = 9'h1FF; m = 6'h00;
    for (i = 0; i < n + 6; i++) begin
      a = (i < n) ? d[i % 32] ^ p[8] ^ p[4] : 1'b0;
      p = {p[7:0], p[8] ^ p[4]};
      w = {a, m};
      m = w[6:1];
      exp_q.push_back({i == 0, 1'b0, ^(w & 7'h5B)});
      exp_q.push_back({2'b00, ^(w & 7'h79)});
      exp_q.push_back({2'b00, ^(w & 7'h65)});
      exp_q.push_back({1'b0, i == n + 5, ^(w & 7'h5B)});
    end
  endtask
  // entered just after a clock edge; returns once the last bit is taken, with it still offered
  task automatic send_frame(input int n, input logic [31:0] d);
    int i, t;
    for (i = 0; i < n; i++) begin
      #1; bit_valid_in = 1'b1; bit_in = d[i % 32]; frame_start_in = (i == 0); frame_last_in = (i == n - 1);
      t = 0;
      do begin @(posedge clk_in); t++; end while (bit_ready_out !== 1'b1 && t < 200);
    end
  endtask
  task automatic compare_all();
    int t;
    #1; bit_valid_in = 1'b0; frame_start_in = 1'b0; frame_last_in = 1'b0;
    t = 0;
    do begin @(posedge clk_in); t++; end while (got_q.size() < exp_q.size() && t < 8000);
    check({1'b0, got_q.size() == exp_q.size()}, 3'h1);
    check({2'b00, frame_error_out}, 3'h0);
    while (exp_q.size() > 0 && got_q.size() > 0) check(got_q.pop_front(), exp_q.pop_front());
    exp_q.delete(); got_q.delete();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic zero_frame();
    logic [8:0] p; logic [15:0] tbl; int i;
    p = 9'h1FF; tbl = 16'h07BE;
    for (i = 0; i < 16; i++) begin
      check({2'b00, p[8] ^ p[4]}, {2'b00, tbl[15 - i]});
      p = {p[7:0], p[8] ^ p[4]};
    end
    expect_frame(16, 32'h0); send_frame(16, 32'h0); compare_all();
  endtask
  task automatic data_frame(); expect_frame(24, 32'hC3A5F1); send_frame(24, 32'hC3A5F1); compare_all(); endtask
  task automatic back_to_back();
    expect_frame(5, 32'h1B); expect_frame(1, 32'h1);
    send_frame(5, 32'h1B); send_frame(1, 32'h1); compare_all();
  endtask
  task automatic fast_frame(); expect_frame(768, 32'h9E3779B9); send_frame(768, 32'h9E3779B9); compare_all(); endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_in);
    #1 rst_in = 1'b0;
    @(posedge clk_in);
    zero_frame(); data_frame(); back_to_back(); fast_frame();
    finish_test();
  end
endmodule // prbs_scrambler_conv_encoder_tb_top
bind prbs_scrambler_conv_encoder prbs_scrambler_conv_encoder_properties i_props (.clk_in(clk_in), .rst_in(rst_in),
  .bit_in(bit_in), .bit_valid_in(bit_valid_in), .frame_start_in(frame_start_in), .frame_last_in(frame_last_in),
  .bit_ready_out(bit_ready_out), .code_ready_in(code_ready_in), .code_bit_out(code_bit_out),
  .code_valid_out(code_valid_out), .code_first_out(code_first_out), .code_last_out(code_last_out),
  .frame_error_out(frame_error_out));
